// [test/i2cm_tgt.sv]
// Behavioural two-wire bus target used as the far side of the sequencer
`timescale 1ns/1ps
module i2cm_tgt
(
   input wire logic scl,
   input wire logic sda,
   input wire logic rd_mode,
   input wire logic ack_en,
   input wire logic [7:0] rd_byte,
   output logic sda_oe
);
   // ==========================================
   // Frame tracking
   int cnt = 0;
   logic active = 1'b0;
   logic fresh = 1'b0;
   always @(negedge sda)
   begin
      if (scl)
      begin
         active = 1'b1;
         fresh = 1'b1;
      end
   end
   always @(posedge sda)
   begin
      if (scl)
         active = 1'b0;
   end
   // Bits are counted on falling clock, so the data line only moves while clock is low
   always @(negedge scl)
   begin
      cnt = fresh ? 0 : cnt + 1;
      fresh = 1'b0;
      if (cnt == 9)
         cnt = 0;
   end
   // ==========================================
   // Line drive: released outside a frame, so the pull-up shows
   assign sda_oe = active && (rd_mode ? (cnt < 8 && !rd_byte[3'(7 - cnt)])
                                      : (cnt == 8 && ack_en));
endmodule

// [test/tb.sv]
// Self-checking bench for the two-wire bus master sequencer
`timescale 1ns/1ps
module tb
   import i2cm_pkg::*;
   ;
   // ==========================================
   // Signals
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] aw_a = 8'h00;
   logic [7:0] ar_a = 8'h00;
   logic [31:0] w_d = 32'h0;
   logic aw_v = 1'b0;
   logic w_v = 1'b0;
   logic b_r = 1'b0;
   logic ar_v = 1'b0;
   logic r_r = 1'b0;
   logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq;
   logic [1:0] b_resp, r_resp, r;
   logic [31:0] r_d, d;
   logic scl_o, scl_oe, sda_o, sda_oe, tgt_oe;
   logic rd_mode = 1'b0;
   logic ack_en = 1'b1;
   logic [7:0] rd_byte = 8'h00;
   wire scl_w = scl_oe ? scl_o : 1'b1;
   wire sda_w = (sda_oe ? sda_o : 1'b1) & ~tgt_oe;
   int bad_count = 0;
   int tests_run = 0;
   int cyc = 0;
   int starts = 0;
   int stops = 0;
   int rises = 0;
   logic [8:0] shreg = 9'h000;
   always #50 clk = ~clk;
   // Short quarter keeps the run brief; the clock sync wait stretches each bit
   i2cm_top #(.QTR(2)) dut_u (.REF_CLK(clk), .RESETN(rst_n),
      .S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_rdy),
      .S_AXI_WDATA(w_d), .S_AXI_WSTRB(4'h3), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_rdy),
      .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r),
      .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_rdy),
      .S_AXI_RDATA(r_d), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r),
      .SERIAL_CLOCK_LINE_I(scl_w), .SERIAL_CLOCK_LINE_O(scl_o),
      .SERIAL_CLOCK_LINE_OE(scl_oe), .SERIAL_DATA_LINE_I(sda_w),
      .SERIAL_DATA_LINE_O(sda_o), .SERIAL_DATA_LINE_OE(sda_oe), .IRQ(irq));
   i2cm_tgt tgt_u (.scl(scl_w), .sda(sda_w), .rd_mode(rd_mode), .ack_en(ack_en),
      .rd_byte(rd_byte), .sda_oe(tgt_oe));
   // ==========================================
   // Wire monitor
   always @(posedge scl_w)
   begin
      shreg <= {shreg[7:0], sda_w};
      rises++;
   end
   always @(negedge sda_w)
      if (scl_w) starts++;
   always @(posedge sda_w)
      if (scl_w) stops++;
   // ==========================================
   // Bus tasks and checks
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      logic done;
      done = 1'b0;
      aw_a <= a;
      w_d <= {16'h0000, v};
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_r <= 1'b1;
      while (!done)
      begin
         @(posedge clk);
         if (aw_v && aw_rdy)
            aw_v <= 1'b0;
         if (w_v && w_rdy)
            w_v <= 1'b0;
         if (b_v)
         begin
            r = b_resp;
            b_r <= 1'b0;
            done = 1'b1;
         end
      end
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a);
      logic done;
      done = 1'b0;
      d = 'x;
      ar_a <= a;
      ar_v <= 1'b1;
      r_r <= 1'b1;
      while (!done)
      begin
         @(posedge clk);
         if (ar_v && ar_rdy)
            ar_v <= 1'b0;
         if (r_v)
         begin
            d = r_d;
            r = r_resp;
            r_r <= 1'b0;
            done = 1'b1;
         end
      end
      @(posedge clk);
   endtask
   // Software starts nothing new until the pending bit drops
   task automatic wait_low(input logic [7:0] a, input int b);
      for (int k = 0; k < 300; k++)
      begin
         rd(a);
         if (d[b] === 1'b0)
            break;
      end
      chk("request_clear", d[b], 1'b0);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_tx();
      rd(OFS_STAT);
      chk("status_rst", d, 32'h0);
      chk("irq_rst", irq, 1'b0);
      wr(OFS_CTRL, 16'h0001 << REQ_START);
      wait_low(OFS_CTRL, REQ_START);
      chk("start_seen", starts, 1);
      chk("held_low", {scl_w, sda_w}, 2'b00);
      wr(OFS_TXB, 16'h00a5);
      rd(OFS_STAT);
      chk("tx_active", d[STA_TX_ACT], 1'b1);
      wr(OFS_TXB, 16'h005a);
      wait_low(OFS_STAT, STA_TX_ACT);
      chk("tx_byte", shreg, 9'h14a);
      rd(OFS_STAT);
      chk("ack_result", d[STA_ACK_RES], 1'b0);
      chk("wcol", d[STA_WRITE_COLLISION_FLAG], 1'b1);
      wr(OFS_IRQ_MASK, 16'h0001 << IRQ_WRITE_COLLISION_FLAG);
      chk("irq_on", irq, 1'b1);
      wr(OFS_IRQ_STAT, 16'h0001 << IRQ_WRITE_COLLISION_FLAG);
      chk("irq_off", irq, 1'b0);
      wr(OFS_STAT, 16'hffff);
      chk("wr_resp", r, RESP_OKAY);
      rd(OFS_STAT);
      chk("wcol_kept", d[STA_WRITE_COLLISION_FLAG], 1'b1);
      chk("unused_bits", d[13:11], 3'b000);
      wr(OFS_STAT, 16'h0000);
      rd(OFS_STAT);
      chk("wcol_clr", d[STA_WRITE_COLLISION_FLAG], 1'b0);
      ack_en <= 1'b0;
      wr(OFS_TXB, 16'h00c3);
      wait_low(OFS_STAT, STA_TX_ACT);
      chk("nack_byte", shreg, 9'h187);
      wr(OFS_STAT, 16'h0000);
      rd(OFS_STAT);
      chk("nack_result", d[STA_ACK_RES], 1'b1);
      ack_en <= 1'b1;
      $display("test transmit done");
   endtask
   task automatic t_rx();
      int n;
      rd_mode <= 1'b1;
      rd_byte <= 8'h96;
      wr(OFS_CTRL, 16'h0001 << REQ_RSTART);
      wait_low(OFS_CTRL, REQ_RSTART);
      chk("restart_seen", starts, 2);
      n = rises;
      wr(OFS_CTRL, 16'h0001 << REQ_RX);
      wait_low(OFS_CTRL, REQ_RX);
      chk("rx_clocks", rises - n, 8);
      rd(OFS_STAT);
      chk("rx_full", d[STA_RBF], 1'b1);
      wr(OFS_CTRL, 16'h0030);
      wait_low(OFS_CTRL, REQ_ACK);
      chk("nack_sent", shreg[0], 1'b1);
      rd_byte <= 8'h69;
      wr(OFS_CTRL, 16'h0028);
      wait_low(OFS_CTRL, REQ_RX);
      rd(OFS_STAT);
      chk("overflow", d[STA_OV], 1'b1);
      rd(OFS_RXB);
      chk("rx_data", d, 32'h96);
      wr(OFS_CTRL, 16'h0010);
      wait_low(OFS_CTRL, REQ_ACK);
      chk("ack_sent", shreg[0], 1'b0);
      rd_mode <= 1'b0;
      $display("test receive done");
   endtask
   // Target pulls the data line low under a sent one: arbitration is lost
   task automatic t_col();
      @(posedge clk);
      rd_mode <= 1'b1;
      rd_byte <= 8'h00;
      wr(OFS_TXB, 16'h0080);
      wait_low(OFS_STAT, STA_TX_ACT);
      rd(OFS_STAT);
      chk("bcl_set", d[STA_BCL], 1'b1);
      chk("tbf_drop", d[STA_TBF], 1'b0);
      rd(OFS_IRQ_STAT);
      chk("irq_bcl", d[IRQ_BCL], 1'b1);
      rd_mode <= 1'b0;
      wr(OFS_STAT, 16'h0000);
      chk("wr_resp_clr", r, RESP_OKAY);
      rd(OFS_STAT);
      chk("bcl_clr", d[STA_BCL], 1'b0);
      $display("test collision done");
   endtask
   task automatic t_stop();
      int n;
      n = stops;
      wr(OFS_CTRL, 16'h0001 << REQ_STOP);
      wait_low(OFS_CTRL, REQ_STOP);
      chk("stop_seen", stops - n, 1);
      chk("released", {scl_w, sda_w}, 2'b11);
      wr(8'h40, 16'h0001);
      chk("unmapped_wresp", r, RESP_SLVERR);
      rd(8'h40);
      chk("unmapped_resp", r, RESP_SLVERR);
      chk("unmapped_data", d, 32'h0);
      $display("test stop done");
   endtask
   // ==========================================
   // Sequence and hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         conclude();
      end
   end
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_tx();
      t_rx();
      t_col();
      t_stop();
      conclude();
   end
endmodule

// [verilog/i2cm_pkg.sv]
// Constants and types of the two-wire bus master sequencer
//
// Function
// - Stored acknowledge value: one sends NACK, zero sends ACK
// - Acknowledge request drives the stored value, cleared by hardware at end
// - Receive request reads a byte, cleared after the eighth bit
// - Stop request makes a Stop condition, cleared when it completes
// - Repeated-start request makes a Repeated Start, cleared at its end
// - Start request makes a Start condition, cleared when it ends
// - Status resets to zero, bits 13 to 11 read zero, only hardware sets flags
// - Last acknowledge result records NACK or ACK while the acknowledge clock is high
// - Transmit-active flag set at byte start, cleared after target acknowledge
// - Transmit buffer write while busy fails and sets write collision flag
// - Byte completing while receive buffer full sets receive overflow flag
package i2cm_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_TXB = 8'h08;
   localparam logic [7:0] OFS_RXB = 8'h0c;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   // ==========================================================
   // Field positions
   localparam int CTL_ACK_VAL = 5;
   localparam int REQ_START = 0;
   localparam int REQ_RSTART = 1;
   localparam int REQ_STOP = 2;
   localparam int REQ_RX = 3;
   localparam int REQ_ACK = 4;
   localparam int STA_ACK_RES = 15;
   localparam int STA_TX_ACT = 14;
   localparam int STA_BCL = 10;
   localparam int STA_WRITE_COLLISION_FLAG = 7;
   localparam int STA_OV = 6;
   localparam int STA_RBF = 1;
   localparam int STA_TBF = 0;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_BCL = 1;
   localparam int IRQ_WRITE_COLLISION_FLAG = 2;
   localparam int IRQ_OV = 3;
   localparam logic [15:0] STAT_RESET = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // ==========================================================
   // Timing: one quarter of a bus bit period
   localparam int CLK_PERIOD_NS = 100;
   localparam int T_QTR_NS = 2500;
   localparam int QTR_CYC = (T_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] TX_ACK_BIT = 4'h8;
   localparam logic [3:0] RX_LAST_BIT = 4'h7;

   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_RSTART, ST_STOP, ST_TXB, ST_RXB, ST_ACK}
      i2cm_state_t;
endpackage

// [verilog/i2cm_top.sv]
// Two-wire bus master sequencer with AXI4-Lite register slave
`timescale 1ns/1ps
module i2cm_top
   import i2cm_pkg::*;
#(
   parameter int QTR = QTR_CYC
)
(
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic SERIAL_CLOCK_LINE_I,
   output logic SERIAL_CLOCK_LINE_O,
   output logic SERIAL_CLOCK_LINE_OE,
   input wire logic SERIAL_DATA_LINE_I,
   output logic SERIAL_DATA_LINE_O,
   output logic SERIAL_DATA_LINE_OE,
   output logic IRQ
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);

   // ==========================================================
   // Line synchronisers
   logic scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q;
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
      end
      else
      begin
         scl_s1_q <= SERIAL_CLOCK_LINE_I;
         scl_s2_q <= scl_s1_q;
         sda_s1_q <= SERIAL_DATA_LINE_I;
         sda_s2_q <= sda_s1_q;
      end
   end

   // ==========================================================
   // AXI4-Lite write channel
   logic awready_q, wready_q, bvalid_q, aw_full_q, w_full_q;
   logic [1:0] bresp_q;
   logic [7:0] waddr_q;
   logic [15:0] wdata_q, wmask_q;
   logic wr_fire, wr_ok;
   assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
   assign wr_ok = waddr_q inside {OFS_CTRL, OFS_STAT, OFS_TXB, OFS_RXB, OFS_IRQ_STAT,
                                  OFS_IRQ_MASK};
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         waddr_q <= 8'h00;
         wdata_q <= 16'h0000;
         wmask_q <= 16'h0000;
      end
      else
      begin
         if (awready_q && S_AXI_AWVALID)
         begin
            awready_q <= 1'b0;
            aw_full_q <= 1'b1;
            waddr_q <= {S_AXI_AWADDR[7:2], 2'b00};
         end
         else if (!aw_full_q && !bvalid_q)
            awready_q <= 1'b1;
         if (wready_q && S_AXI_WVALID)
         begin
            wready_q <= 1'b0;
            w_full_q <= 1'b1;
            wdata_q <= S_AXI_WDATA[15:0];
            wmask_q <= {{8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};
         end
         else if (!w_full_q && !bvalid_q)
            wready_q <= 1'b1;
         if (wr_fire)
         begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bvalid_q && S_AXI_BREADY)
            bvalid_q <= 1'b0;
      end
   end
   assign S_AXI_AWREADY = awready_q;
   assign S_AXI_WREADY = wready_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;

   // ==========================================================
   // Engine status shared with the registers
   i2cm_state_t st_q;
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   logic [15:0] qcnt_q;
   logic [7:0] shift_q, tx_buf_q, rx_buf_q;
   logic [4:0] req_q, done_vec;
   logic ack_val_q, ack_res_q, tx_act_q, bcl_q, write_collision_flag_q, ov_q, rbf_q, tbf_q;
   logic [3:0] irq_stat_q, irq_mask_q;
   logic tick, last_ph, busy, col_evt, write_collision_flag_evt, rx_done, tx_done, ov_evt;
   logic [15:0] stat_word;
   logic w_ctrl, w_stat, w_txb, w_istat, w_imask;
   assign w_ctrl = wr_fire && waddr_q == OFS_CTRL;
   assign w_stat = wr_fire && waddr_q == OFS_STAT;
   assign w_txb = wr_fire && waddr_q == OFS_TXB && wmask_q[0];
   assign w_istat = wr_fire && waddr_q == OFS_IRQ_STAT;
   assign w_imask = wr_fire && waddr_q == OFS_IRQ_MASK;
   assign busy = st_q != ST_IDLE || |req_q;
   assign write_collision_flag_evt = w_txb && busy;
   assign stat_word = {ack_res_q, tx_act_q, 3'b000, bcl_q, 2'b00, write_collision_flag_q, ov_q, 4'h0,
                       rbf_q, tbf_q};

   // ==========================================================
   // AXI4-Lite read channel
   logic arready_q, rvalid_q, rd_rx;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   assign rd_rx = arready_q && S_AXI_ARVALID && {S_AXI_ARADDR[7:2], 2'b00} == OFS_RXB;
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h00000000;
      end
      else if (arready_q && S_AXI_ARVALID)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rresp_q <= RESP_OKAY;
         case ({S_AXI_ARADDR[7:2], 2'b00})
            OFS_CTRL: rdata_q <= {26'h0000000, ack_val_q, req_q};
            OFS_STAT: rdata_q <= {16'h0000, stat_word};
            OFS_TXB: rdata_q <= {24'h000000, tx_buf_q};
            OFS_RXB: rdata_q <= {24'h000000, rx_buf_q};
            OFS_IRQ_STAT: rdata_q <= {28'h0000000, irq_stat_q};
            OFS_IRQ_MASK: rdata_q <= {28'h0000000, irq_mask_q};
            default:
            begin
               rdata_q <= 32'h00000000;
               rresp_q <= RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid_q && S_AXI_RREADY)
         rvalid_q <= 1'b0;
      else if (!rvalid_q)
         arready_q <= 1'b1;
   end
   assign S_AXI_ARREADY = arready_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;

   // ==========================================================
   // Control bits: software sets requests, hardware clears them
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         ack_val_q <= 1'b0;
         req_q <= 5'h00;
      end
      else
      begin
         if (w_ctrl && wmask_q[0])
            ack_val_q <= wdata_q[CTL_ACK_VAL];
         // A request set in its own clearing cycle survives
         req_q <= (req_q & ~done_vec) | ((w_ctrl && wmask_q[0]) ? wdata_q[4:0] : 5'h00);
      end
   end

   // ==========================================================
   // Status flags and byte buffers
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         bcl_q <= STAT_RESET[STA_BCL];
         write_collision_flag_q <= STAT_RESET[STA_WRITE_COLLISION_FLAG];
         ov_q <= STAT_RESET[STA_OV];
         rbf_q <= STAT_RESET[STA_RBF];
         tbf_q <= STAT_RESET[STA_TBF];
         tx_buf_q <= 8'h00;
         rx_buf_q <= 8'h00;
      end
      else
      begin
         // Flags clear by writing zero; hardware set wins
         bcl_q <= col_evt | (bcl_q & ~(w_stat & wmask_q[STA_BCL] & ~wdata_q[STA_BCL]));
         write_collision_flag_q <= write_collision_flag_evt | (write_collision_flag_q & ~(w_stat & wmask_q[STA_WRITE_COLLISION_FLAG] &
                    ~wdata_q[STA_WRITE_COLLISION_FLAG]));
         ov_q <= ov_evt | (ov_q & ~(w_stat & wmask_q[STA_OV] & ~wdata_q[STA_OV]));
         if (w_txb && !busy)
         begin
            tx_buf_q <= wdata_q[7:0];
            tbf_q <= 1'b1;
         end
         else if (tx_done || col_evt)
            tbf_q <= 1'b0;
         // Overflowing byte is dropped so the unread one is kept
         if (rx_done && !rbf_q)
         begin
            rx_buf_q <= shift_q;
            rbf_q <= 1'b1;
         end
         else if (rd_rx)
            rbf_q <= 1'b0;
      end
   end

   // ==========================================================
   // Interrupts
   logic irq_q;
   logic [3:0] irq_ev;
   assign irq_ev = {ov_evt, write_collision_flag_evt, col_evt, |done_vec | tx_done};
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         irq_stat_q <= 4'h0;
         irq_mask_q <= 4'h0;
         irq_q <= 1'b0;
      end
      else
      begin
         irq_stat_q <= irq_ev | (irq_stat_q & ~((w_istat && wmask_q[0]) ? wdata_q[3:0] : 4'h0));
         if (w_imask && wmask_q[0])
            irq_mask_q <= wdata_q[3:0];
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end
   assign IRQ = irq_q;

   // ==========================================================
   // Sequence engine: each bus step is four quarter periods, except Start and Stop, which take three
   logic sda_low_q, scl_low_q, drv_lvl_q, seq_end, cur_bit;
   assign tick = st_q != ST_IDLE && qcnt_q == 16'(QTR - 1);
   always_comb
   begin
      last_ph = ph_q == 2'd3;
      seq_end = 1'b0;
      cur_bit = 1'b1;
      case (st_q)
         ST_START: last_ph = ph_q == 2'd2;
         ST_STOP: last_ph = ph_q == 2'd2;
         ST_TXB: cur_bit = bit_q == TX_ACK_BIT ? 1'b1 : shift_q[7];
         ST_ACK: cur_bit = ack_val_q;
         default: cur_bit = 1'b1;
      endcase
      case (st_q)
         ST_TXB: seq_end = tick && last_ph && bit_q == TX_ACK_BIT;
         ST_RXB: seq_end = tick && last_ph && bit_q == RX_LAST_BIT;
         ST_IDLE: seq_end = 1'b0;
         default: seq_end = tick && last_ph;
      endcase
   end
   assign done_vec = {seq_end && st_q == ST_ACK, rx_done, seq_end && st_q == ST_STOP,
                      seq_end && st_q == ST_RSTART, seq_end && st_q == ST_START};
   assign rx_done = seq_end && st_q == ST_RXB;
   assign tx_done = seq_end && st_q == ST_TXB;
   assign ov_evt = rx_done && rbf_q;
   assign col_evt = tick && ph_q == 2'd1 && st_q == ST_TXB && bit_q != TX_ACK_BIT &&
                    cur_bit && !sda_s2_q;

   // Quarter timer, held while a target stretches the clock low
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
         qcnt_q <= 16'h0000;
      else if (st_q == ST_IDLE || tick || (ph_q == 2'd1 && !scl_s2_q))
         qcnt_q <= 16'h0000;
      else
         qcnt_q <= qcnt_q + 16'h0001;
   end

   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         st_q <= ST_IDLE;
         ph_q <= 2'd0;
         bit_q <= 4'h0;
         shift_q <= 8'h00;
         sda_low_q <= 1'b0;
         scl_low_q <= 1'b0;
         ack_res_q <= STAT_RESET[STA_ACK_RES];
         tx_act_q <= STAT_RESET[STA_TX_ACT];
      end
      else if (st_q == ST_IDLE)
      begin
         ph_q <= 2'd0;
         bit_q <= 4'h0;
         if (req_q[REQ_START])
         begin
            st_q <= ST_START;
            sda_low_q <= 1'b0;
            scl_low_q <= 1'b0;
         end
         else if (req_q[REQ_RSTART])
         begin
            st_q <= ST_RSTART;
            sda_low_q <= 1'b0;
         end
         else if (req_q[REQ_STOP])
         begin
            st_q <= ST_STOP;
            sda_low_q <= 1'b1;
         end
         else if (req_q[REQ_RX])
         begin
            st_q <= ST_RXB;
            sda_low_q <= 1'b0;
         end
         else if (req_q[REQ_ACK])
         begin
            st_q <= ST_ACK;
            sda_low_q <= ~ack_val_q;
         end
         else if (tbf_q)
         begin
            st_q <= ST_TXB;
            shift_q <= tx_buf_q;
            sda_low_q <= ~tx_buf_q[7];
            tx_act_q <= 1'b1;
         end
      end
      else if (col_evt)
      begin
         // Lost arbitration: let go of both lines at once
         st_q <= ST_IDLE;
         sda_low_q <= 1'b0;
         scl_low_q <= 1'b0;
         tx_act_q <= 1'b0;
      end
      else if (tick)
      begin
         ph_q <= ph_q + 2'd1;
         if (seq_end)
         begin
            st_q <= ST_IDLE;
            if (st_q == ST_TXB)
               tx_act_q <= 1'b0;
         end
         case (st_q)
            ST_START:
               if (ph_q == 2'd0)
                  sda_low_q <= 1'b1;
               else if (ph_q == 2'd1)
                  scl_low_q <= 1'b1;
            ST_RSTART:
               if (ph_q == 2'd0)
                  scl_low_q <= 1'b0;
               else if (ph_q == 2'd1)
                  sda_low_q <= 1'b1;
               else if (ph_q == 2'd2)
                  scl_low_q <= 1'b1;
            ST_STOP:
               if (ph_q == 2'd0)
                  scl_low_q <= 1'b0;
               else if (ph_q == 2'd1)
                  sda_low_q <= 1'b0;
            default:
               if (ph_q == 2'd0)
                  scl_low_q <= 1'b0;
               else if (ph_q == 2'd1)
               begin
                  if (st_q == ST_RXB)
                     shift_q <= {shift_q[6:0], sda_s2_q};
                  else if (st_q == ST_TXB && bit_q == TX_ACK_BIT)
                     ack_res_q <= sda_s2_q;
               end
               else if (ph_q == 2'd2)
                  scl_low_q <= 1'b1;
               else
               begin
                  bit_q <= bit_q + 4'h1;
                  if (st_q == ST_TXB && bit_q != TX_ACK_BIT)
                  begin
                     shift_q <= {shift_q[6:0], 1'b1};
                     sda_low_q <= bit_q == RX_LAST_BIT ? 1'b0 : ~shift_q[6];
                  end
                  else if (seq_end && st_q == ST_ACK)
                     sda_low_q <= 1'b0;
               end
         endcase
      end
   end

   // ==========================================================
   // Open-drain pins: only ever pull low
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
         drv_lvl_q <= 1'b0;
      else
         drv_lvl_q <= 1'b0;
   end
   assign SERIAL_CLOCK_LINE_O = drv_lvl_q;
   assign SERIAL_DATA_LINE_O = drv_lvl_q;
   assign SERIAL_CLOCK_LINE_OE = scl_low_q;
   assign SERIAL_DATA_LINE_OE = sda_low_q;

   // ==========================================================
   // Assertions
   AST_ACK_VALUE: assert property (st_q == ST_ACK |-> sda_low_q == ~ack_val_q)
      else $error("ack slot drives wrong value");
   AST_ACK_CLEAR: assert property (done_vec[REQ_ACK] |=> st_q == ST_IDLE &&
      scl_low_q && !sda_low_q && !req_q[REQ_ACK])
      else $error("ack request not finished");
   AST_RX_CLEAR: assert property ($fell(req_q[REQ_RX]) |-> $past(bit_q) == RX_LAST_BIT)
      else $error("receive request cleared early");
   AST_STOP_END: assert property ($fell(req_q[REQ_STOP]) |-> !sda_low_q && !scl_low_q)
      else $error("stop did not release lines");
   AST_RS_END: assert property ($fell(req_q[REQ_RSTART]) |-> sda_low_q && scl_low_q)
      else $error("repeated start end state wrong");
   AST_START_END: assert property ($fell(req_q[REQ_START]) |-> sda_low_q && scl_low_q)
      else $error("start end state wrong");
   AST_BCL_CAUSE: assert property ($rose(bcl_q) |-> $past(col_evt))
      else $error("collision flag set without cause");
   AST_ACK_RES: assert property (st_q == ST_TXB && bit_q == TX_ACK_BIT && ph_q == 2'd1 && tick
      |=> ack_res_q == $past(sda_s2_q))
      else $error("ack result not recorded");
   AST_TX_ACT: assert property (st_q == ST_TXB |-> tx_act_q)
      else $error("transmit active missing");
   AST_WRITE_COLLISION_FLAG: assert property (write_collision_flag_evt |=> write_collision_flag_q && tx_buf_q == $past(tx_buf_q))
      else $error("write collision not flagged");
   AST_OV: assert property (ov_evt |=> ov_q && rx_buf_q == $past(rx_buf_q))
      else $error("overflow not flagged");
endmodule
